// [design/ebtp_pin_sync.sv]
// external count pin synchroniser and edge detector
// assumes pin is asynchronous to sys_clk; clocked on rising edge only
`timescale 1ns/100ps
module ebtp_pin_sync (
	// clock and reset
	input wire logic sysClk,
	input wire logic resetN,
	// pin in, edges out
	input wire logic pinIn,
	output ebtp_pkg::ebtp_edge_type edges
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ebtp_sync_type;
	ebtp_sync_type st_ff;
	ebtp_sync_type nxt_st;
	// two-stage sample, third stage for edge compare
	always_comb begin
		nxt_st.s1 = pinIn; // see [RULE13]
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
	end
	always_ff @(posedge sysClk or negedge resetN) begin
		if (!resetN) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	// edges from second and third stages only, two edges of latency; see [RULE15]
	assign edges.rise = st_ff.s2 & ~st_ff.s3; // see [RULE14]
	assign edges.fall = ~st_ff.s2 & st_ff.s3; // see [RULE14]
endmodule : ebtp_pin_sync

// [design/ebtp_timer.sv]
// eight-bit up counter with clock select, shared prescaler and overflow flag
// assumes AHB-Lite master on sys_clk; vector acknowledge and global enable from core
`timescale 1ns/100ps
//
// Overview of operation
// [RULE1] clock select picks stop, div1..1024, pin edges
// [RULE2] count up on enable, hold when stopped
// [RULE3] software count write beats increment
// [RULE4] count up only, wrap 0xFF to 0x00
// [RULE5] overflow flag set on wrap, held until cleared
// [RULE6] flag cleared by vector or writing one
// [RULE7] irq equals flag and enable and global
// [RULE8] count always readable and writable
// [RULE9] prescaler free running, shared, separate taps
// [RULE10] first prescaled tick within 1..N+1 cycles
// [RULE11] prescaler reset affects both timers
// [RULE12] reset bit self clears, reads zero
// [RULE13] pin sampled each cycle via synchroniser
// [RULE14] one pulse per selected pin edge
// [RULE15] pin edge reaches counter in few cycles
// [RULE16] software switches pin mode when pin stable
// [RULE17] pin half period exceeds one clock
// [RULE18] pin counts even when driven as output
// [RULE19] pin edges never prescaled
// [RULE20] single clock, timer tick is enable
// [RULE21] reset clears count, flag, select, enable
module ebtp_timer (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// core side
	input wire logic globalIrqEnable,
	input wire logic overflowVectorAck,
	output logic overflowIrq,
	// external count pin, sampled whatever its direction
	input wire logic externalCountPin,
	// shared prescaler to companion timer
	output logic [ebtp_pkg::PRE_W-1:0] prescalerValue
);
	typedef struct packed {
		logic [7:0] count;
		logic [2:0] clockSelect;
		logic overflowFlag;
		logic overflowIrqEnable;
		logic gieShadow;
		logic [ebtp_pkg::PRE_W-1:0] prescaler;
		logic prescalerResetBit;
		logic dphValid;
		logic dphWrite;
		logic [7:0] dphAddr;
		logic [31:0] rdata;
		logic irq;
	} ebtp_state_type;

	ebtp_state_type st_ff;
	ebtp_state_type nxt_st;
	ebtp_pkg::ebtp_edge_type pinEdges;
	ebtp_pkg::ebtp_ahbreq_type req;
	logic [ebtp_pkg::PRE_W-1:0] prePrev;
	logic timerCountEnable;
	logic wrCount;
	logic wrFlags;
	logic [7:0] wbyte;

	// pin synchroniser and edge detector
	ebtp_pin_sync u_pin_sync (
		.sysClk(sys_clk),
		.resetN(reset_n),
		.pinIn(externalCountPin),
		.edges(pinEdges)
	);

	// tap pulse: bit k-1 of the prescaler falls, i.e. counter crosses multiple of 2^k
	function automatic logic tap_pulse(input logic [ebtp_pkg::PRE_W-1:0] nowV,
		input logic [ebtp_pkg::PRE_W-1:0] wasV, input int k);
		tap_pulse = wasV[k-1] & ~nowV[k-1];
	endfunction : tap_pulse

	// read data for a register offset
	function automatic logic [31:0] read_mux(input ebtp_state_type s, input logic [7:0] a);
		read_mux = 32'h0000_0000;
		unique case (a)
			ebtp_pkg::CTRL_ADDR: read_mux[ebtp_pkg::CS_LSB +: ebtp_pkg::CS_W] = s.clockSelect;
			ebtp_pkg::COUNT_ADDR: read_mux[7:0] = s.count; // see [RULE8]
			ebtp_pkg::MASK_ADDR: read_mux[ebtp_pkg::TOIE_BIT] = s.overflowIrqEnable;
			ebtp_pkg::FLAGS_ADDR: read_mux[ebtp_pkg::OVF_BIT] = s.overflowFlag;
			ebtp_pkg::PSRST_ADDR: read_mux = 32'h0000_0000; // see [RULE12]
			ebtp_pkg::GIE_ADDR: read_mux[ebtp_pkg::GIE_BIT] = s.gieShadow;
			default: read_mux = 32'h0000_0000;
		endcase
	endfunction : read_mux

	// bus request bundle
	assign req.sel = hsel;
	assign req.trans = htrans;
	assign req.write = hwrite;
	assign req.size = hsize;
	assign req.addr = haddr;

	// current prescaler value minus one, not a registered copy, to form tap pulses
	assign prePrev = st_ff.prescaler - ebtp_pkg::PRE_W'(1);

	// clock select multiplexer; tick is a single-cycle enable
	always_comb begin
		timerCountEnable = 1'b0;
		unique case (ebtp_pkg::ebtp_cs_type'(st_ff.clockSelect)) // see [RULE1]
			ebtp_pkg::CS_STOP: timerCountEnable = 1'b0; // see [RULE2]
			ebtp_pkg::CS_DIV1: timerCountEnable = 1'b1;
			ebtp_pkg::CS_DIV8: timerCountEnable = tap_pulse(st_ff.prescaler, prePrev, ebtp_pkg::TAP8); // see [RULE10]
			ebtp_pkg::CS_DIV64: timerCountEnable = tap_pulse(st_ff.prescaler, prePrev, ebtp_pkg::TAP64);
			ebtp_pkg::CS_DIV256: timerCountEnable = tap_pulse(st_ff.prescaler, prePrev, ebtp_pkg::TAP256);
			ebtp_pkg::CS_DIV1024: timerCountEnable = (st_ff.prescaler == '0) && !st_ff.prescalerResetBit;
			ebtp_pkg::CS_EXTFALL: timerCountEnable = pinEdges.fall; // see [RULE19]
			ebtp_pkg::CS_EXTRISE: timerCountEnable = pinEdges.rise; // see [RULE18]
		endcase
	end

	// data phase write decode
	assign wbyte = hwdata[7:0];
	assign wrCount = st_ff.dphValid && st_ff.dphWrite && (st_ff.dphAddr == ebtp_pkg::COUNT_ADDR);
	assign wrFlags = st_ff.dphValid && st_ff.dphWrite && (st_ff.dphAddr == ebtp_pkg::FLAGS_ADDR);

	// next state
	always_comb begin
		nxt_st = st_ff;
		// prescaler runs regardless of clock select; reset restarts it
		if (st_ff.prescalerResetBit) begin
			nxt_st.prescaler = '0; // see [RULE11]
			nxt_st.prescalerResetBit = 1'b0; // see [RULE12]
		end else begin
			nxt_st.prescaler = st_ff.prescaler + ebtp_pkg::PRE_W'(1); // see [RULE9]
		end
		// counter: increment and wrap, write wins
		if (timerCountEnable) begin
			nxt_st.count = st_ff.count + 8'h01; // see [RULE4]
		end
		if (wrCount) begin
			nxt_st.count = wbyte; // see [RULE3]
		end
		// overflow flag: clears first, set wins over clear
		if (overflowVectorAck) begin
			nxt_st.overflowFlag = 1'b0; // see [RULE6]
		end
		if (wrFlags && wbyte[ebtp_pkg::OVF_BIT]) begin
			nxt_st.overflowFlag = 1'b0; // see [RULE6]
		end
		if (timerCountEnable && !wrCount && (st_ff.count == ebtp_pkg::MAX_COUNT)) begin
			nxt_st.overflowFlag = 1'b1; // see [RULE5]
		end
		// other register writes
		if (st_ff.dphValid && st_ff.dphWrite) begin
			unique case (st_ff.dphAddr)
				ebtp_pkg::CTRL_ADDR: nxt_st.clockSelect = wbyte[ebtp_pkg::CS_LSB +: ebtp_pkg::CS_W];
				ebtp_pkg::MASK_ADDR: nxt_st.overflowIrqEnable = wbyte[ebtp_pkg::TOIE_BIT];
				ebtp_pkg::PSRST_ADDR: begin
					if (wbyte[ebtp_pkg::PSR_BIT]) begin
						nxt_st.prescalerResetBit = 1'b1; // see [RULE12]
					end
				end
				default: nxt_st.dphAddr = st_ff.dphAddr;
			endcase
		end
		nxt_st.gieShadow = globalIrqEnable;
		// interrupt request from next flag and enables
		nxt_st.irq = nxt_st.overflowFlag && nxt_st.overflowIrqEnable && globalIrqEnable; // see [RULE7]
		// address phase capture
		nxt_st.dphValid = 1'b0;
		if (hready) begin
			nxt_st.dphValid = req.sel && req.trans[1];
			nxt_st.dphWrite = req.write;
			nxt_st.dphAddr = req.addr[7:0];
		end
		// read data registered for the following data phase
		nxt_st.rdata = '0;
		if (hready && req.sel && req.trans[1] && !req.write) begin
			nxt_st.rdata = read_mux(st_ff, req.addr[7:0]);
		end
	end

	// single clock for all state; reset clears everything
	always_ff @(posedge sys_clk or negedge reset_n) begin // see [RULE20]
		if (!reset_n) begin
			st_ff <= '0; // see [RULE21]
		end else begin
			st_ff <= nxt_st;
		end
	end

	// read data, irq and prescaler outputs straight from flip-flops; ready and response tied off: zero wait state, always OKAY
	assign hrdata = st_ff.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign overflowIrq = st_ff.irq;
	assign prescalerValue = st_ff.prescaler;
endmodule : ebtp_timer

// [include/ebtp_pkg.sv]
// package for the eight-bit timer with shared prescaler
// assumes a single system clock domain and an AHB-Lite register slave
package ebtp_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] COUNT_ADDR = 8'h04;
	localparam logic [7:0] MASK_ADDR = 8'h08;
	localparam logic [7:0] FLAGS_ADDR = 8'h0C;
	localparam logic [7:0] PSRST_ADDR = 8'h10;
	localparam logic [7:0] GIE_ADDR = 8'h14;
	// field positions
	localparam int CS_LSB = 0;
	localparam int CS_W = 3;
	localparam int OVF_BIT = 0;
	localparam int TOIE_BIT = 0;
	localparam int PSR_BIT = 0;
	localparam int GIE_BIT = 0;
	// count reset and limit values
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] MAX_COUNT = 8'hFF;
	localparam logic [7:0] BOTTOM_COUNT = 8'h00;
	// prescaler geometry
	localparam int PRE_W = 10;
	localparam int TAP8 = 3;
	localparam int TAP64 = 6;
	localparam int TAP256 = 8;
	localparam int TAP1024 = 10;
	// clock select encodings
	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIV1 = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXTFALL = 3'h6,
		CS_EXTRISE = 3'h7
	} ebtp_cs_type;
	// AHB-Lite request carrier
	typedef struct packed {
		logic sel;
		logic [1:0] trans;
		logic write;
		logic [2:0] size;
		logic [31:0] addr;
	} ebtp_ahbreq_type;
	// pin edge detector output carrier
	typedef struct packed {
		logic rise;
		logic fall;
	} ebtp_edge_type;
endpackage : ebtp_pkg

// [verif/ebtp_pin_src.sv]
// pin source standing in for the external count signal
// assumes sys_clk as time base; pin idles low between bursts
`timescale 1ns/100ps
module ebtp_pin_src (
	// time base and request
	input wire logic sys_clk,
	input wire logic start,
	input wire logic [7:0] pulses,
	// pin and status
	output logic pin,
	output logic busy
);
	logic [7:0] left = 8'h00;
	logic [1:0] ph = 2'h0;
	initial pin = 1'b0;
	assign busy = left != 8'h00;
	// toggle every third cycle, stable low when idle
	always @(posedge sys_clk) begin
		if (start) begin
			left <= pulses;
		end else if (busy) begin
			ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
			if (ph == 2'h2) begin
				pin <= ~pin;
				left <= left - {7'h0, pin};
			end
		end
	end
endmodule : ebtp_pin_src

// [verif/ebtp_timer_monitor.sv]
// port checker for the eight-bit timer
// assumes one clock domain; bound at the foot of this file
`timescale 1ns/100ps
module ebtp_timer_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// core and prescaler
	input wire logic globalIrqEnable,
	input wire logic overflowVectorAck,
	input wire logic overflowIrq,
	input wire logic [ebtp_pkg::PRE_W-1:0] prescalerValue
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	// address phase taken
	logic take;
	assign take = hready && hsel && htrans[1];
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("slave stalled or errored");
	a_rdata_idle: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
		else $error("read data outside data phase");
	a_count_width: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_psr_reads0: assert property (take && !hwrite && haddr[7:0] == ebtp_pkg::PSRST_ADDR |=> hrdata == 32'h0)
		else $error("prescaler reset bit read nonzero");
	a_psr_restart: assert property (take && hwrite && haddr[7:0] == ebtp_pkg::PSRST_ADDR ##1 hwdata[0]
		|-> ##[1:3] prescalerValue == '0)
		else $error("prescaler not restarted");
	a_pre_runs: assert property (prescalerValue != '0 |-> prescalerValue == $past(prescalerValue) + 1'b1)
		else $error("prescaler not free running");
	a_irq_gated: assert property (overflowIrq |-> $past(globalIrqEnable))
		else $error("irq without global enable");
	a_ack_clears: assert property (overflowVectorAck |-> ##2 !overflowIrq)
		else $error("irq stays after vector");
endmodule : ebtp_timer_monitor
bind ebtp_timer ebtp_timer_monitor mon (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .hreadyout, .hresp, .globalIrqEnable, .overflowVectorAck, .overflowIrq, .prescalerValue);

// [verif/ebtp_timer_tb.sv]
// self-checking bench for the eight-bit timer
// assumes package, design, pin source and checker compiled first
`timescale 1ns/100ps
module ebtp_timer_tb;
	logic sys_clk, reset_n = 1'b0, hsel = 1'b1, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic globalIrqEnable = 1'b0, overflowVectorAck = 1'b0, overflowIrq, externalCountPin, start = 1'b0, busy;
	logic [7:0] pulses = 8'h00;
	logic [ebtp_pkg::PRE_W-1:0] prescalerValue;
	int n_errors = 0, compares = 0;
	assign hready = hreadyout;
	ebtp_timer uut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .globalIrqEnable, .overflowVectorAck, .overflowIrq, .externalCountPin, .prescalerValue);
	ebtp_pin_src pin (.sys_clk, .start, .pulses, .pin(externalCountPin), .busy);
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// one single word: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	// a burst of pin pulses, then time for the sync stages
	task automatic pins(input logic [7:0] n);
		pulses <= n;
		start <= 1'b1;
		tick(1);
		start <= 1'b0;
		do tick(1); while (busy === 1'b1);
		tick(6);
	endtask : pins
	task automatic t_reset;
		rd(ebtp_pkg::CTRL_ADDR, 32'h0);
		rd(ebtp_pkg::COUNT_ADDR, 32'h0);
		rd(ebtp_pkg::MASK_ADDR, 32'h0);
		rd(ebtp_pkg::FLAGS_ADDR, 32'h0);
		rd(ebtp_pkg::PSRST_ADDR, 32'h0);
		rd(8'h18, 32'h0);
	endtask : t_reset
	// stopped count holds, then undivided ticks wrap it
	task automatic t_wrap;
		bus(1'b1, ebtp_pkg::COUNT_ADDR, 32'hFE);
		tick(4);
		rd(ebtp_pkg::COUNT_ADDR, 32'hFE);
		bus(1'b1, ebtp_pkg::CTRL_ADDR, 32'h1);
		bus(1'b1, ebtp_pkg::MASK_ADDR, 32'h1);
		bus(1'b1, ebtp_pkg::CTRL_ADDR, 32'h0);
		rd(ebtp_pkg::FLAGS_ADDR, 32'h1);
		// four enabled edges from FE: wrap then two more
		rd(ebtp_pkg::COUNT_ADDR, 32'h02);
		bus(1'b1, ebtp_pkg::FLAGS_ADDR, 32'h0);
		rd(ebtp_pkg::FLAGS_ADDR, 32'h1);
	endtask : t_wrap
	// request gated by global enable, dropped by vector
	task automatic t_irq;
		globalIrqEnable <= 1'b1;
		tick(3);
		chk(overflowIrq, 1'b1);
		rd(ebtp_pkg::GIE_ADDR, 32'h1);
		globalIrqEnable <= 1'b0;
		tick(3);
		chk(overflowIrq, 1'b0);
		rd(ebtp_pkg::GIE_ADDR, 32'h0);
		globalIrqEnable <= 1'b1;
		overflowVectorAck <= 1'b1;
		tick(1);
		overflowVectorAck <= 1'b0;
		tick(3);
		rd(ebtp_pkg::FLAGS_ADDR, 32'h0);
		chk(overflowIrq, 1'b0);
	endtask : t_irq
	// pin edges in both modes, flag cleared by a one
	task automatic t_ext;
		globalIrqEnable <= 1'b0;
		bus(1'b1, ebtp_pkg::CTRL_ADDR, 32'h7);
		bus(1'b1, ebtp_pkg::COUNT_ADDR, 32'hFE);
		pins(8'h03);
		rd(ebtp_pkg::COUNT_ADDR, 32'h01);
		rd(ebtp_pkg::FLAGS_ADDR, 32'h1);
		bus(1'b1, ebtp_pkg::FLAGS_ADDR, 32'h1);
		rd(ebtp_pkg::FLAGS_ADDR, 32'h0);
		bus(1'b1, ebtp_pkg::CTRL_ADDR, 32'h6);
		bus(1'b1, ebtp_pkg::COUNT_ADDR, 32'h0);
		pins(8'h04);
		rd(ebtp_pkg::COUNT_ADDR, 32'h04);
	endtask : t_ext
	// each tap over 2N cycles yields two or three ticks
	task automatic t_pre;
		int dv[4] = '{8, 64, 256, 1024};
		bus(1'b1, ebtp_pkg::PSRST_ADDR, 32'h1);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ebtp_pkg::COUNT_ADDR, 32'h0);
			bus(1'b1, ebtp_pkg::CTRL_ADDR, 32'(i + 2));
			tick(2 * dv[i]);
			bus(1'b1, ebtp_pkg::CTRL_ADDR, 32'h0);
			bus(1'b0, ebtp_pkg::COUNT_ADDR, 32'h0);
			chk(q >= 32'h2 && q <= 32'h3, 1'b1);
		end
	endtask : t_pre
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		tick(1);
		t_reset;
		t_wrap;
		t_irq;
		t_ext;
		t_pre;
		close_out;
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		close_out;
	end
endmodule : ebtp_timer_tb
